// ### sim/dhc_host_ctrl_bench.sv
// Self-checking bench for the host pin update controller
`timescale 1ns/10ps
`default_nettype none
module dhc_host_ctrl_bench;
  typedef struct packed {
    logic [4:0] a;
    logic [13:0] off;
    logic [13:0] dat;
    logic [13:0] exp;
  } dhc_row_s;
  logic clk = 1'b0, rst_n = 1'b0, clear_n = 1'b1, reset_pin_n = 1'b1;
  logic power_down = 1'b0, chain_enable = 1'b0;
  logic en = 1'b1, sclk = 1'b0, sdin = 1'b0;
  logic [1:0] apin = 2'h0;
  logic isel, cs_n, wr_n, rhi, rlo, absel, ld_n, oe_n, busy_n, dval;
  logic sout, dmode, lowp, pdn, hiz;
  logic [13:0] db, dword;
  logic [4:0] addr;
  logic [1:0] twa;
  logic [5:0] dch;
  dhc_pkg::dhc_word_t seen [64];
  int n_valid = 0, n_fail = 0, samples_checked = 0, v0, n;
  dhc_pkg::dhc_word_t wa, wb;
  // Reset gain is one step below full scale, so codes come out one low
  dhc_row_s rows [4] = '{'{5'h00, 14'h2000, 14'h3fff, 14'h3ffe},
    '{5'h1f, 14'h2000, 14'h0001, 14'h0000},
    '{5'h05, 14'h2003, 14'h0010, 14'h0012},
    '{5'h0a, 14'h1fff, 14'h0001, 14'h0000}};

  initial forever #5 clk = ~clk;

  dhc_host_model host (.clk(clk), .interface_select(isel),
    .chip_select_n(cs_n), .write_n(wr_n), .parallel_data_bus(db),
    .channel_address(addr), .reg_class_hi(rhi), .reg_class_lo(rlo),
    .ab_select(absel), .load_update_n(ld_n));

  dhc_host_ctrl #(.RST_CYCLES(50), .CLR_CYCLES(50), .CALC_CYCLES(12))
  dhc_host_ctrl_inst (.clk(clk), .rst_n(rst_n), .clk_en(en),
    .interface_select(isel), .chip_select_n(cs_n), .write_n(wr_n),
    .parallel_data_bus(db), .channel_address(addr), .reg_class_hi(rhi),
    .reg_class_lo(rlo), .ab_select(absel), .load_update_n(ld_n),
    .clear_n(clear_n), .reset_pin_n(reset_pin_n),
    .power_down(power_down), .chain_enable(chain_enable),
    .bus_addr_pin0(apin[0]), .bus_addr_pin1(apin[1]), .serial_shift_in(sdin),
    .serial_clk(sclk), .serial_out(sout), .serial_out_oe_n(oe_n),
    .busy_n(busy_n), .daisy_chain_mode(dmode), .two_wire_addr(twa),
    .analog_low_power(lowp), .out_pulldown(pdn), .out_high_z(hiz),
    .dac_valid(dval), .dac_channel(dch), .dac_word(dword));

  always @(posedge clk) begin
    if (dval === 1'b1) begin
      seen[dch] <= dword;
      n_valid <= n_valid + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask : chk

  // Bounded wait for the controller to go idle
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && busy_n !== 1'b1; i++) @(negedge clk);
    chk("idle", 1, busy_n);
  endtask : wait_idle

  task automatic wrw(input logic [4:0] a, input logic [1:0] c,
                     input logic [13:0] d, input logic ab);
    host.wr(a, c, d, ab);
    wait_idle();
  endtask : wrw

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk("busy_in_boot", 0, busy_n);
    wait_idle();
    $display("test boot done");
    foreach (rows[i]) begin
      wrw(rows[i].a, 2'h2, rows[i].off, 1'b0);
      wrw(rows[i].a, 2'h3, rows[i].dat, 1'b0);
      host.ld();
      wait_idle();
      chk("word", rows[i].exp, seen[rows[i].a]);
    end
    $display("test table done");
    host.wr(5'h07, 2'h3, 14'h0abc, 1'b0);
    host.ld();
    wait_idle();
    // Busy rises for one cycle before the stored transfer starts
    repeat (3) @(negedge clk);
    wait_idle();
    chk("stored_load", 14'h0abb, seen[7]);
    $display("test stored load done");
    wrw(5'h0c, 2'h0, 14'h0001, 1'b0);
    wrw(5'h09, 2'h3, 14'h0111, 1'b0);
    wrw(5'h09, 2'h3, 14'h0222, 1'b1);
    host.ld();
    wait_idle();
    wa = seen[9];
    host.ld();
    wait_idle();
    wb = seen[9];
    chk("toggle", 14'h0331, wa ^ wb);
    wrw(5'h0c, 2'h0, 14'h0000, 1'b0);
    $display("test toggle done");
    wrw(5'h02, 2'h0, 14'h0155, 1'b0);
    v0 = n_valid;
    @(negedge clk);
    clear_n = 1'b0;
    for (n = 0; n < 20 && busy_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 400 && busy_n !== 1'b1; n++) @(negedge clk);
    chk("clear_len", 1, n >= 46 && n <= 60);
    chk("clear_word", 14'h0155, seen[3]);
    chk("clear_count", 40, n_valid - v0);
    clear_n = 1'b1;
    $display("test clear done");
    @(negedge clk);
    reset_pin_n = 1'b0;
    v0 = n_valid;
    host.ld();
    chk("busy_in_reset", 0, busy_n);
    wait_idle();
    repeat (20) @(negedge clk);
    chk("load_dropped", v0, n_valid);
    host.ld();
    wait_idle();
    chk("reset_word", 14'h0000, seen[0]);
    reset_pin_n = 1'b1;
    $display("test reset pin done");
    power_down = 1'b1;
    chain_enable = 1'b1;
    host.interface_select = 1'b1;
    host.chip_select_n = 1'b0;
    sdin = 1'b1;
    @(negedge clk);
    sclk = 1'b1;
    repeat (10) @(negedge clk);
    chk("low_power", 1, lowp);
    chk("high_z", 1, hiz);
    chk("pulldown", 0, pdn);
    chk("chain", 1, dmode);
    chk("sdo_drive", 0, oe_n);
    chk("sdo", 1, sout);
    sclk = 1'b0;
    sdin = 1'b0;
    host.chip_select_n = 1'b1;
    power_down = 1'b0;
    host.interface_select = 1'b0;
    repeat (10) @(negedge clk);
    chk("awake", 0, lowp);
    chk("sdo_off", 1, oe_n);
    wrw(5'h08, 2'h0, 14'h0001, 1'b0);
    power_down = 1'b1;
    repeat (10) @(negedge clk);
    chk("pd_load", 1, pdn);
    chk("pd_no_hiz", 0, hiz);
    power_down = 1'b0;
    $display("test pins done");
    // Address pins move while frozen; nothing may follow until enabled
    en = 1'b0;
    apin = 2'h2;
    repeat (5) @(negedge clk);
    chk("frozen", 0, twa);
    en = 1'b1;
    repeat (5) @(negedge clk);
    chk("bus_addr", 2, twa);
    $display("test freeze done");
    tally_and_finish();
  end
endmodule : dhc_host_ctrl_bench
`default_nettype wire

// ### sim/dhc_host_ctrl_chk.sv
// Assertion checker for the host pin update controller
`timescale 1ns/10ps
`default_nettype none
module dhc_host_ctrl_chk #(
  parameter int CHANNELS = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic reg_class_hi,
  input wire logic reg_class_lo,
  input wire logic load_update_n,
  input wire logic clear_n,
  input wire logic reset_pin_n,
  input wire logic power_down,
  input wire logic chain_enable,
  input wire logic serial_out_oe_n,
  input wire logic busy_n,
  input wire logic daisy_chain_mode,
  input wire logic analog_low_power,
  input wire logic dac_valid,
  input wire logic [5:0] dac_channel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_boot_busy_low: assert property ($rose(rst_n) |-> !busy_n [*8])
    else $error("busy released too soon after power-on");
  a_boot_ends: assert property ($rose(rst_n) |-> ##[1:80] busy_n)
    else $error("power-on sequence did not finish");
  a_pin_reset_busy: assert property (
    $fell(reset_pin_n) && busy_n |-> ##[1:8] !busy_n)
    else $error("reset pin edge did not raise busy");
  a_clear_busy: assert property (
    $fell(clear_n) && busy_n |-> ##[1:8] !busy_n)
    else $error("clear edge did not raise busy");
  a_write_calc: assert property (
    $rose(write_n) && !chip_select_n && !interface_select && busy_n
    && reg_class_hi && reg_class_lo |-> ##[1:8] !busy_n)
    else $error("data write did not start a calculation");
  a_load_busy: assert property (
    $fell(load_update_n) && busy_n |-> ##[1:8] !busy_n)
    else $error("load-update did not start a transfer");
  a_chan_range: assert property (
    dac_valid |-> dac_channel < 6'(CHANNELS))
    else $error("updated channel out of range");
  a_pd_follows: assert property (power_down [*6] |-> analog_low_power)
    else $error("power-down level not followed");
  a_chain_mode: assert property (
    (interface_select && chain_enable) [*6] |-> daisy_chain_mode)
    else $error("daisy-chain mode not entered");
  a_par_no_drive: assert property (
    !interface_select [*6] |-> serial_out_oe_n)
    else $error("serial output driven in parallel mode");

  c_write: cover property ($rose(write_n) && !chip_select_n);
  c_load: cover property (dac_valid && !busy_n);
  c_clear: cover property ($fell(clear_n));
endmodule : dhc_host_ctrl_chk
bind dhc_host_ctrl dhc_host_ctrl_chk #(.CHANNELS(CHANNELS)) dhc_host_ctrl_chk_inst (
  .clk(clk), .rst_n(rst_n), .interface_select(interface_select),
  .chip_select_n(chip_select_n), .write_n(write_n),
  .reg_class_hi(reg_class_hi), .reg_class_lo(reg_class_lo),
  .load_update_n(load_update_n), .clear_n(clear_n),
  .reset_pin_n(reset_pin_n), .power_down(power_down),
  .chain_enable(chain_enable), .serial_out_oe_n(serial_out_oe_n),
  .busy_n(busy_n), .daisy_chain_mode(daisy_chain_mode),
  .analog_low_power(analog_low_power), .dac_valid(dac_valid),
  .dac_channel(dac_channel));
`default_nettype wire

// ### sim/dhc_host_model.sv
// Host processor model driving the parallel write and load-update pins
`timescale 1ns/10ps
`default_nettype none
module dhc_host_model (
  input wire logic clk,
  output logic interface_select,
  output logic chip_select_n,
  output logic write_n,
  output logic [13:0] parallel_data_bus,
  output logic [4:0] channel_address,
  output logic reg_class_hi,
  output logic reg_class_lo,
  output logic ab_select,
  output logic load_update_n
);
  initial begin
    interface_select = 1'b0;
    chip_select_n = 1'b1;
    write_n = 1'b1;
    parallel_data_bus = 14'h0000;
    channel_address = 5'h00;
    {reg_class_hi, reg_class_lo} = 2'h0;
    ab_select = 1'b0;
    load_update_n = 1'b1;
  end

  // Hold everything 4 cycles either side of the strobe edge
  task automatic wr(input logic [4:0] a, input logic [1:0] c,
                    input logic [13:0] d, input logic ab);
    @(negedge clk);
    chip_select_n = 1'b0;
    channel_address = a;
    {reg_class_hi, reg_class_lo} = c;
    parallel_data_bus = d;
    ab_select = ab;
    write_n = 1'b0;
    repeat (4) @(negedge clk);
    write_n = 1'b1;
    repeat (4) @(negedge clk);
    chip_select_n = 1'b1;
    // Released bus shows the inverse so stale data cannot pass
    parallel_data_bus = ~d;
    channel_address = ~a;
  endtask : wr

  task automatic ld();
    @(negedge clk);
    load_update_n = 1'b0;
    repeat (4) @(negedge clk);
    load_update_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : ld
endmodule : dhc_host_model
`default_nettype wire

// ### src/dhc_defines.svh
// Timing constants and field layouts for the host pin update controller
`ifndef DHC_DEFINES_SVH
`define DHC_DEFINES_SVH

`define DHC_CLK_MHZ 100
`define DHC_CLR_BUSY_US 35
`define DHC_CLR_CYCLES (`DHC_CLR_BUSY_US * `DHC_CLK_MHZ)
`define DHC_RST_BUSY_US 270
`define DHC_RST_CYCLES (`DHC_RST_BUSY_US * `DHC_CLK_MHZ)
`define DHC_CALC_CYCLES 16
`define DHC_DATA_W 14
`define DHC_ADDR_W 5
`define DHC_CHANNELS 40
`define DHC_CLASS_SFR 2'h0
`define DHC_CLASS_GAIN 2'h1
`define DHC_CLASS_OFFSET 2'h2
`define DHC_CLASS_DATA 2'h3
`define DHC_RAW_RESET 14'h0000
`define DHC_GAIN_RESET 14'h3ffe
`define DHC_OFFSET_RESET 14'h2000
`define DHC_CLRCODE_RESET 14'h0000
`define DHC_SFR_CLRCODE 5'h02
`define DHC_SFR_TOGGLE 5'h0c
`define DHC_SFR_PDMODE 5'h08

`endif

// ### src/dhc_host_ctrl.sv
// Parallel write port, busy and load-update control of the converter
`timescale 1ns/10ps
`default_nettype none
`include "dhc_defines.svh"
// Overview of operation
// RULE1 - Write strobe rising edge with chip select low captures data bus.
// RULE2 - Data word is fourteen bits, top line is the MSB.
// RULE3 - Five address lines select one of forty channel locations; code reaches only channels 0 to 31.
// RULE4 - Class inputs pick data, offset, gain or special registers.
// RULE5 - Toggle mode: select pin picks A or B; else A.
// RULE6 - In toggle mode each load-update swaps outputs between A and B.
// RULE7 - Busy low during calculation; input writes accepted, outputs held.
// RULE8 - Load-update low while busy high transfers all inputs at once; code walks the channels one per clock cycle.
// RULE9 - Load-update during calculation is remembered, done when busy rises.
// RULE10 - During reset busy low, interface off, load-updates discarded.
// RULE11 - Clear falling edge loads clear code everywhere, busy low 35 us; code acts on clear edges only in idle state.
// RULE12 - Reset falling edge restores defaults, busy low 270 us.
// RULE13 - After reset sequence, reset pin ignored until next falling edge.
// RULE14 - Power-down level puts analog in low power; serial stays active.
// RULE15 - Power-down output state follows configured power-down mode.
// RULE16 - Host uses chip select as frame sync in serial mode.
// RULE17 - Serial mode with chain enable high selects daisy-chain mode.
// RULE18 - Serial output tristates; shifts on rising serial clock edge.
// RULE19 - Two address pins set the two-wire bus address.
// RULE20 - Host drives interface select low parallel, high serial.
// RULE21 - Host holds chip select low to address the device.
// RULE22 - Strobe, clear, reset, load-update are synchronised, edges detected.
module dhc_host_ctrl #(
  parameter int CHANNELS = `DHC_CHANNELS,
  parameter int CLR_CYCLES = `DHC_CLR_CYCLES,
  parameter int RST_CYCLES = `DHC_RST_CYCLES,
  parameter int CALC_CYCLES = `DHC_CALC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic interface_select,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic [13:0] parallel_data_bus,
  input wire logic [4:0] channel_address,
  input wire logic reg_class_hi,
  input wire logic reg_class_lo,
  input wire logic ab_select,
  input wire logic load_update_n,
  input wire logic clear_n,
  input wire logic reset_pin_n,
  input wire logic power_down,
  input wire logic chain_enable,
  input wire logic bus_addr_pin0,
  input wire logic bus_addr_pin1,
  input wire logic serial_shift_in,
  input wire logic serial_clk,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic busy_n,
  output logic daisy_chain_mode,
  output logic [1:0] two_wire_addr,
  output logic analog_low_power,
  output logic out_pulldown,
  output logic out_high_z,
  output logic dac_valid,
  output logic [5:0] dac_channel,
  output logic [13:0] dac_word
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 40 || CLR_CYCLES < CHANNELS ||
        RST_CYCLES < CHANNELS || CALC_CYCLES < 1)
      $error("dhc_host_ctrl: unsupported parameter values");
  end

  localparam int CW = 32;

  // Raw inputs synchronised before use
  logic wr_lvl, wr_rise, wr_fall;
  logic ld_lvl, ld_rise, ld_fall;
  logic cl_lvl, cl_rise, cl_fall;
  logic rs_lvl, rs_rise, rs_fall;
  logic [13:0] db_meta_q, db_q;
  logic [6:0] ad_meta_q, ad_q;
  logic [6:0] lv_meta_q, lv_q;
  logic [1:0] sck_meta_q, sck_q;
  logic sck_prev_q;

  dhc_sync_edge #(.RESET_VAL(1'b1)) u_wr (.clk(clk), .rst_n(rst_n),
    .en(clk_en), .pin(write_n), .level(wr_lvl), .rise(wr_rise),
    .fall(wr_fall)); // RULE22
  dhc_sync_edge #(.RESET_VAL(1'b1)) u_ld (.clk(clk), .rst_n(rst_n),
    .en(clk_en), .pin(load_update_n), .level(ld_lvl), .rise(ld_rise),
    .fall(ld_fall)); // RULE22
  dhc_sync_edge #(.RESET_VAL(1'b1)) u_cl (.clk(clk), .rst_n(rst_n),
    .en(clk_en), .pin(clear_n), .level(cl_lvl), .rise(cl_rise),
    .fall(cl_fall)); // RULE22
  dhc_sync_edge #(.RESET_VAL(1'b1)) u_rs (.clk(clk), .rst_n(rst_n),
    .en(clk_en), .pin(reset_pin_n), .level(rs_lvl), .rise(rs_rise),
    .fall(rs_fall)); // RULE22

  // Data, address and levels are sampled through two stages as well
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      db_meta_q <= 14'h0000;
      db_q <= 14'h0000;
      ad_meta_q <= 7'h00;
      ad_q <= 7'h00;
      lv_meta_q <= 7'h40;
      lv_q <= 7'h40;
      sck_meta_q <= 2'h0;
      sck_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end else if (clk_en) begin
      db_meta_q <= parallel_data_bus;
      db_q <= db_meta_q;
      ad_meta_q <= {channel_address, reg_class_hi, reg_class_lo};
      ad_q <= ad_meta_q;
      lv_meta_q <= {chip_select_n, interface_select, ab_select,
                    power_down, chain_enable, bus_addr_pin1, bus_addr_pin0};
      lv_q <= lv_meta_q;
      sck_meta_q <= {serial_clk, serial_shift_in};
      sck_q <= sck_meta_q;
      sck_prev_q <= sck_q[1];
    end
  end

  logic cs_n_s, ser_s, ab_s, pd_s, chain_enable_s;
  assign cs_n_s = lv_q[6];
  assign ser_s = lv_q[5];
  assign ab_s = lv_q[4];
  assign pd_s = lv_q[3];
  assign chain_enable_s = lv_q[2];

  function automatic logic chan_ok(input logic [4:0] a, input int n);
    chan_ok = int'(a) < n;
  endfunction : chan_ok

  // Register storage
  dhc_pkg::dhc_word_t raw_a_q [CHANNELS];
  dhc_pkg::dhc_word_t raw_b_q [CHANNELS];
  dhc_pkg::dhc_word_t gain_q [CHANNELS];
  dhc_pkg::dhc_word_t offs_q [CHANNELS];
  dhc_pkg::dhc_word_t dac_a_q [CHANNELS];
  dhc_pkg::dhc_word_t dac_b_q [CHANNELS];
  dhc_pkg::dhc_word_t clr_code_q;
  logic toggle_mode_q;
  logic pd_mode_q;
  logic out_sel_b_q;

  dhc_pkg::dhc_state_e state_q;
  logic [CW-1:0] cnt_q;
  logic [5:0] walk_q;
  logic ld_pending_q;
  logic calc_pending_q;
  logic is_par;

  assign is_par = ~ser_s;

  // Accepted parallel write: only outside reset, parallel mode, cs low
  logic wr_take;
  assign wr_take = wr_rise & ~cs_n_s & is_par &
                   (state_q != dhc_pkg::ST_RESET); // RULE1 RULE10
  logic [4:0] wr_ch;
  logic [1:0] wr_cls;
  assign wr_ch = ad_q[6:2]; // RULE3
  assign wr_cls = ad_q[1:0]; // RULE4
  logic wr_b;
  assign wr_b = toggle_mode_q & ab_s; // RULE5

  // Input registers: written in any non-reset state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        raw_a_q[i] <= `DHC_RAW_RESET;
        raw_b_q[i] <= `DHC_RAW_RESET;
        gain_q[i] <= `DHC_GAIN_RESET;
        offs_q[i] <= `DHC_OFFSET_RESET;
      end
    end else if (clk_en) begin
      if (state_q == dhc_pkg::ST_RESET && cnt_q == 0) begin
        for (int i = 0; i < CHANNELS; i++) begin
          raw_a_q[i] <= `DHC_RAW_RESET; // RULE12
          raw_b_q[i] <= `DHC_RAW_RESET;
          gain_q[i] <= `DHC_GAIN_RESET;
          offs_q[i] <= `DHC_OFFSET_RESET;
        end
      end else if (wr_take && chan_ok(wr_ch, CHANNELS)) begin
        case (wr_cls)
          `DHC_CLASS_DATA: begin
            if (wr_b) raw_b_q[wr_ch] <= db_q; // RULE2 RULE5
            else raw_a_q[wr_ch] <= db_q;
          end
          `DHC_CLASS_GAIN: gain_q[wr_ch] <= db_q;
          `DHC_CLASS_OFFSET: offs_q[wr_ch] <= db_q;
          default: ;
        endcase
      end
    end
  end

  // Special function registers reached with class zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_code_q <= `DHC_CLRCODE_RESET;
      toggle_mode_q <= 1'b0;
      pd_mode_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == dhc_pkg::ST_RESET && cnt_q == 0) begin
        clr_code_q <= `DHC_CLRCODE_RESET;
        toggle_mode_q <= 1'b0;
        pd_mode_q <= 1'b0;
      end else if (wr_take && wr_cls == `DHC_CLASS_SFR) begin // RULE4
        case (wr_ch)
          `DHC_SFR_CLRCODE: clr_code_q <= db_q;
          `DHC_SFR_TOGGLE: toggle_mode_q <= db_q[0];
          `DHC_SFR_PDMODE: pd_mode_q <= db_q[0]; // RULE15
          default: ;
        endcase
      end
    end
  end

  // Corrected value: raw scaled by gain plus offset, centred
  function automatic dhc_pkg::dhc_word_t correct(input dhc_pkg::dhc_word_t x,
      input dhc_pkg::dhc_word_t m, input dhc_pkg::dhc_word_t c);
    logic [28:0] prod;
    logic [15:0] sum;
    prod = {15'h0000, x} * ({15'h0000, m} + 29'h0000001);
    sum = 16'(prod[28:14]) + 16'(c) - 16'h2000;
    if (sum[15]) correct = 14'h0000;
    else if (sum[14]) correct = 14'h3fff;
    else correct = sum[13:0];
  endfunction : correct

  // Calculation request raised by any data, gain or offset class write
  logic calc_req;
  assign calc_req = wr_take && wr_cls != `DHC_CLASS_SFR;

  // Sequencer: reset, calculation, load and clear walks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dhc_pkg::ST_RESET;
      cnt_q <= CW'(RST_CYCLES - 1);
      walk_q <= 6'h00;
      ld_pending_q <= 1'b0;
      calc_pending_q <= 1'b0;
    end else if (clk_en) begin
      if (rs_fall) begin
        state_q <= dhc_pkg::ST_RESET; // RULE12 RULE13
        cnt_q <= CW'(RST_CYCLES - 1);
        ld_pending_q <= 1'b0;
        calc_pending_q <= 1'b0;
      end else begin
        if (calc_req) calc_pending_q <= 1'b1;
        case (state_q)
          dhc_pkg::ST_RESET: begin
            ld_pending_q <= 1'b0; // RULE10
            if (cnt_q == 0) state_q <= dhc_pkg::ST_IDLE;
            else cnt_q <= cnt_q - CW'(1);
          end
          dhc_pkg::ST_IDLE: begin
            if (cl_fall) begin
              state_q <= dhc_pkg::ST_CLEAR; // RULE11
              cnt_q <= CW'(CLR_CYCLES - 1);
              walk_q <= 6'h00;
            end else if (ld_fall || ld_pending_q) begin
              state_q <= dhc_pkg::ST_LOAD; // RULE8 RULE9
              walk_q <= 6'h00;
              ld_pending_q <= 1'b0;
            end else if (calc_pending_q || calc_req) begin
              state_q <= dhc_pkg::ST_CALC; // RULE7
              cnt_q <= CW'(CALC_CYCLES - 1);
              calc_pending_q <= 1'b0;
            end
          end
          dhc_pkg::ST_CALC: begin
            if (ld_fall) ld_pending_q <= 1'b1; // RULE9
            if (cnt_q == 0) state_q <= dhc_pkg::ST_IDLE;
            else cnt_q <= cnt_q - CW'(1);
          end
          dhc_pkg::ST_LOAD: begin
            if (ld_fall) ld_pending_q <= 1'b1;
            if (int'(walk_q) == CHANNELS - 1) state_q <= dhc_pkg::ST_IDLE;
            else walk_q <= walk_q + 6'h01;
          end
          dhc_pkg::ST_CLEAR: begin
            if (ld_fall) ld_pending_q <= 1'b1;
            if (int'(walk_q) < CHANNELS - 1) walk_q <= walk_q + 6'h01;
            if (cnt_q == 0) state_q <= dhc_pkg::ST_IDLE;
            else cnt_q <= cnt_q - CW'(1);
          end
          default: state_q <= dhc_pkg::ST_RESET;
        endcase
      end
    end
  end

  // DAC registers and the toggle output select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dac_a_q[i] <= 14'h0000;
        dac_b_q[i] <= 14'h0000;
      end
      out_sel_b_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == dhc_pkg::ST_RESET) begin
        for (int i = 0; i < CHANNELS; i++) begin
          dac_a_q[i] <= 14'h0000; // RULE12
          dac_b_q[i] <= 14'h0000;
        end
        out_sel_b_q <= 1'b0;
      end else if (state_q == dhc_pkg::ST_LOAD) begin
        dac_a_q[walk_q] <= correct(raw_a_q[walk_q], gain_q[walk_q],
                                   offs_q[walk_q]); // RULE8
        dac_b_q[walk_q] <= correct(raw_b_q[walk_q], gain_q[walk_q],
                                   offs_q[walk_q]);
        if (int'(walk_q) == CHANNELS - 1 && toggle_mode_q)
          out_sel_b_q <= ~out_sel_b_q; // RULE6
      end else if (state_q == dhc_pkg::ST_CLEAR) begin
        dac_a_q[walk_q] <= clr_code_q; // RULE11
        dac_b_q[walk_q] <= clr_code_q;
        out_sel_b_q <= 1'b0;
      end
    end
  end

  // Output word presented per channel as it is updated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_valid <= 1'b0;
      dac_channel <= 6'h00;
      dac_word <= 14'h0000;
    end else if (clk_en) begin
      dac_valid <= (state_q == dhc_pkg::ST_LOAD) ||
                   (state_q == dhc_pkg::ST_CLEAR &&
                    cnt_q >= CW'(CLR_CYCLES - CHANNELS)); // RULE11
      dac_channel <= walk_q;
      if (state_q == dhc_pkg::ST_CLEAR) dac_word <= clr_code_q;
      else if (toggle_mode_q && !out_sel_b_q)
        dac_word <= correct(raw_b_q[walk_q], gain_q[walk_q],
                            offs_q[walk_q]); // RULE6
      else
        dac_word <= correct(raw_a_q[walk_q], gain_q[walk_q],
                            offs_q[walk_q]);
    end
  end

  // Busy and pin-function outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_n <= 1'b0;
      daisy_chain_mode <= 1'b0;
      two_wire_addr <= 2'h0;
      analog_low_power <= 1'b0;
      out_pulldown <= 1'b0;
      out_high_z <= 1'b0;
    end else if (clk_en) begin
      busy_n <= (state_q == dhc_pkg::ST_IDLE) && !rs_fall && !cl_fall
                && !ld_fall && !calc_req; // RULE7 RULE10 RULE11
      daisy_chain_mode <= ser_s & chain_enable_s; // RULE17
      two_wire_addr <= lv_q[1:0]; // RULE19
      analog_low_power <= pd_s; // RULE14
      out_pulldown <= pd_s & pd_mode_q; // RULE15
      out_high_z <= pd_s & ~pd_mode_q; // RULE15
    end
  end

  // Serial out follows the daisy-chain input on rising serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else if (clk_en) begin
      serial_out_oe_n <= ~(ser_s & ~cs_n_s); // RULE18
      if (sck_q[1] && !sck_prev_q) serial_out <= sck_q[0]; // RULE18
    end
  end

  logic unused_ok;
  assign unused_ok = ^{wr_lvl, wr_fall, ld_lvl, ld_rise, cl_lvl, cl_rise,
                       rs_lvl, rs_rise};
endmodule : dhc_host_ctrl
`default_nettype wire

// ### src/dhc_pkg.sv
// Types shared by the host pin update controller
package dhc_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_IDLE = 3'h1,
    ST_CALC = 3'h2,
    ST_LOAD = 3'h3,
    ST_CLEAR = 3'h4
  } dhc_state_e;
  typedef logic [13:0] dhc_word_t;
endpackage : dhc_pkg

// ### src/dhc_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module dhc_sync_edge #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
      prev_q <= RESET_VAL;
    end else if (en) begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = en & sync_q & ~prev_q;
  assign fall = en & ~sync_q & prev_q;
endmodule : dhc_sync_edge
`default_nettype wire
